// *** tb/radio_sleep_wake_controller_tb.sv ***
/* Self-checking bench for the sleep and wake controller.
   Assumes a zero-wait AHB-Lite slave and the full 1 ms time base. */
`timescale 1ns/1ns
module radio_sleep_wake_controller_tb;
  logic clk_i, rst_n_i, hsel_i, hwrite_i, data_activity_i, sync_received_i, sync_missed_i;
  logic [31:0] haddr_i, hwdata_i, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [21:0] min_sync_wake_i;
  wire [31:0] hrdata_o;
  wire hready_i, hreadyout_o, hresp_o, asleep_o, network_wake_o, pin;
  int mismatches, num_checks;
  assign hready_i = hreadyout_o;
  radio_sleep_wake_controller radio_sleep_wake_controller_inst (.clk_i, .rst_n_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .sleep_request_pin_i(pin), .data_activity_i, .sync_received_i, .sync_missed_i,
    .min_sync_wake_i, .asleep_o, .network_wake_o);
  sleep_host_model sleep_host_model_inst (.sleep_request_pin_o(pin));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready_i !== 1'b1 && n < 50);
    if (hready_i !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    hwrite_i <= w;
    haddr_i <= {20'h0, a};
    htrans_i <= 2'b10;
    wait_ready();
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
    check({31'h0, hresp_o}, 32'h0);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task wr_chk(input logic [11:0] a, input logic [31:0] v, input logic [31:0] e);
    bus(1'b1, a, v);
    rd_chk(a, e);
  endtask
  task wait_wake(input logic e);
    int n;
    n = 0;
    // Outputs are looked at mid-cycle, away from the edge that moves them
    @(negedge clk_i);
    while (network_wake_o !== e && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check({31'h0, network_wake_o}, {31'h0, e});
    check({31'h0, asleep_o}, {31'h0, e});
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    @(posedge clk_i);
  endtask
  task t_reset_values();
    rd_chk(12'h000, 32'h0);
    rd_chk(12'h004, 32'h2);
    rd_chk(12'h008, 32'h7d0);
    rd_chk(12'h00c, 32'hc8);
    rd_chk(12'h014, 32'h1);
    rd_chk(12'h018, 32'h0);
    rd_chk(12'h010, 32'h0);
    rd_chk(12'h020, 32'h0);
  endtask
  task t_modes();
    logic [31:0] prev;
    prev = 32'h0;
    for (int i = 0; i < 16; i++) begin
      if (i inside {0, 1, 4, 5, 7, 8}) prev = i;
      wr_chk(12'h000, i, prev);
    end
    wr_chk(12'h000, 32'h0, 32'h0);
  endtask
  task t_options();
    wr_chk(12'h004, 32'h3, 32'h2);
    wr_chk(12'h004, 32'h13d, 32'h13d);
    wr_chk(12'h004, 32'h101, 32'h101);
    wr_chk(12'h004, 32'h2, 32'h2);
  endtask
  task t_ranges();
    wr_chk(12'h008, 32'h44, 32'h7d0);
    wr_chk(12'h008, 32'h45, 32'h45);
    wr_chk(12'h008, 32'h36ee81, 32'h45);
    wr_chk(12'h008, 32'h36ee80, 32'h36ee80);
    wr_chk(12'h00c, 32'h0, 32'hc8);
    wr_chk(12'h00c, 32'h15f901, 32'hc8);
    wr_chk(12'h00c, 32'h15f900, 32'h15f900);
    wr_chk(12'h00c, 32'h1, 32'h1);
    wr_chk(12'h014, 32'h0, 32'h1);
    wr_chk(12'h014, 32'hffff, 32'hffff);
  endtask
  task t_pin();
    wr_chk(12'h000, 32'h1, 32'h1);
    sleep_host_model_inst.set_pin(1'b1);
    wait_wake(1'b0);
    rd_chk(12'h01c, 32'h9);
    sleep_host_model_inst.set_pin(1'b0);
    wait_wake(1'b1);
    sleep_host_model_inst.set_pin(1'b1);
    wait_wake(1'b0);
    wr_chk(12'h000, 32'h0, 32'h0);
    repeat (10) @(posedge clk_i);
    wait_wake(1'b1);
    sleep_host_model_inst.set_pin(1'b0);
    @(posedge clk_i);
  endtask
  task t_cyclic();
    wr_chk(12'h000, 32'h4, 32'h4);
    wait_wake(1'b1);
    rd_chk(12'h01c, 32'h2);
    wr_chk(12'h008, 32'h45, 32'h45);
    min_sync_wake_i <= 22'h000100;
    wr_chk(12'h000, 32'h8, 32'h8);
    rd_chk(12'h008, 32'h100);
    min_sync_wake_i <= 22'h000000;
    wr_chk(12'h000, 32'h0, 32'h0);
    rd_chk(12'h010, 32'h0);
  endtask
  task t_tally();
    sync_missed_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sync_missed_i <= 1'b0;
    rd_chk(12'h018, 32'h3);
    wr_chk(12'h018, 32'h0, 32'h0);
    // Held high: one miss per cycle, enough to reach saturation
    sync_missed_i <= 1'b1;
    repeat (65540) @(posedge clk_i);
    sync_missed_i <= 1'b0;
    rd_chk(12'h018, 32'hffff);
  endtask
  initial begin
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    htrans_i = 2'b00;
    hsize_i = 3'h2;
    data_activity_i = 1'b0;
    sync_received_i = 1'b0;
    sync_missed_i = 1'b0;
    min_sync_wake_i = 22'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset_values();
    t_modes();
    t_options();
    t_ranges();
    t_pin();
    t_cyclic();
    t_tally();
    test_done();
  end
endmodule // radio_sleep_wake_controller_tb

// *** tb/sleep_host_model.sv ***
/* Host that drives the sleep request pin.
   Assumes the pin is asynchronous to the block clock. */
`timescale 1ns/1ns
module sleep_host_model (
  output logic sleep_request_pin_o
);
  initial sleep_request_pin_o = 1'b0;
  // Mid-cycle change exercises the block's synchroniser
  task set_pin(input logic v);
    #7 sleep_request_pin_o = v;
  endtask
endmodule // sleep_host_model

// *** tb/sleep_wake_asserts.sv ***
/* Port checker for the sleep and wake controller.
   Assumes one clock, zero-wait reads and the block's register offsets. */
`timescale 1ns/1ns
module sleep_wake_asserts (
  input wire clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire network_wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
  wire [11:0] a = haddr_i[11:0];
  mode_code_a: assert property (rd && a == 12'h000 |=> hrdata_o inside {0, 1, 4, 5, 7, 8})
    else $error("mode reads outside accepted set");
  reset_awake_a: assert property ($rose(rst_n_i) |-> network_wake_o)
    else $error("not awake after reset");
  opt_pair_a: assert property (rd && a == 12'h004 |=> !(hrdata_o[0] && hrdata_o[1]))
    else $error("option bits 0 and 1 both set");
  opt_width_a: assert property (rd && a == 12'h004 |=> hrdata_o[31:9] == 23'h0)
    else $error("option upper bits set");
  wake_range_a: assert property (rd && a == 12'h008 |=> hrdata_o >= 32'h45)
    else $error("wake period below floor");
  sleep_range_a: assert property (rd && a == 12'h00c |=> hrdata_o inside {[1:32'h15f900]})
    else $error("sleep period out of range");
  full_wake_a: assert property (rd && a == 12'h014 |=> hrdata_o inside {[1:32'hffff]})
    else $error("full wake count out of range");
  tally_width_a: assert property (rd && a == 12'h018 |=> hrdata_o[31:16] == 16'h0)
    else $error("tally wider than 16 bits");
endmodule // sleep_wake_asserts

bind radio_sleep_wake_controller sleep_wake_asserts sleep_wake_asserts_inst (.clk_i, .rst_n_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .network_wake_o);

// *** verilog/radio_sleep_wake_controller.v ***
/*
  Sleep and wake controller for a radio module, with an AHB-Lite register
  slave. Assumes the host drives the sleep request pin asynchronously and
  that activity and sync events come from same-clock logic as 1-cycle pulses.
*/
`timescale 1ns/1ns
`include "sleep_wake_defs.vh"

module radio_sleep_wake_controller (
  input wire clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire sleep_request_pin_i,
  input wire data_activity_i,
  input wire sync_received_i,
  input wire sync_missed_i,
  input wire [21:0] min_sync_wake_i,
  output reg asleep_o,
  output reg network_wake_o
);

  // Sequencer states.
  // AWAKE rests here in modes 0 and 7, and in mode 1 while the pin is low.
  // SLEEP powers the radio down; the sleep period or the pin level runs it.
  // WAKE is the cyclic awake window, timed in milliseconds.
  // CHECK is the short look for pending data on a reduced wake cycle.
  // Codes are plain binary; spare codes fall back to AWAKE.
  // The status register exposes the code, so keep the encoding stable.

  localparam [2:0] ST_AWAKE = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_WAKE = 3'h2;
  localparam [2:0] ST_CHECK = 3'h3;

  // Software-visible settings.
  // mode holds only accepted codes, so the decode below never sees junk.
  // options keeps the defined bits only; undefined bits read back zero.
  // wake_period is in ms and sleep_period in 10 ms steps.
  // cycles_per_full_wake is never zero, which keeps full_due well defined.
  // missed_sync_cycles is read-only and restarts on every sync message.
  // missed_sync_tally saturates rather than wrapping, so a long outage
  // cannot masquerade as a healthy link.

  reg [3:0] mode;
  reg [8:0] options;
  reg [21:0] wake_period;
  reg [20:0] sleep_period;
  reg [15:0] cycles_per_full_wake;
  reg [15:0] missed_sync_cycles;
  reg [15:0] missed_sync_tally;

  // Sequencer state and its timers.
  // phase_cnt counts ms in WAKE and CHECK, and 10 ms steps in SLEEP;
  // it is wide enough for the largest wake period.
  // period_cnt counts reduced wake cycles between full wakes.
  // ms_div and ten_div form the 1 ms and 10 ms enable pulses.

  reg [2:0] state;
  reg [21:0] phase_cnt;
  reg [15:0] period_cnt;
  reg [15:0] ms_div;
  reg [3:0] ten_div;
  wire ms_tick = (ms_div == `MS_CYCLES - 1);
  wire ten_tick = ms_tick && (ten_div == `TEN_MS_PER_MS - 1);

  // Host sleep request pin.
  // It arrives from outside the clock domain, so only pin_sync and
  // pin_prev are read by logic; pin_meta feeds nothing but pin_sync.
  // pin_prev resets to the idle low level, so no false edge after reset.

  reg pin_meta;
  reg pin_sync;
  reg pin_prev;
  wire pin_fall = pin_prev && !pin_sync;

  // Register bus.
  // Every transfer completes with no wait state, so hreadyout is tied
  // high and the response is always OKAY.
  // A write is latched in its address phase and applied at the end of
  // its data phase, when hwdata is valid.
  // Only single aligned word transfers are expected; hsize is not decoded,
  // so a narrow write would still update the whole register.

  // AHB-Lite: zero-wait slave, always OKAY
  reg wr_pend;
  reg [11:0] wr_addr;
  wire ahb_go = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  wire is_async = (mode == `MODE_ASYNC) || (mode == `MODE_ASYNC_PIN);
  wire is_sync = (mode == `MODE_SYNC);
  wire cyclic = is_async || is_sync;
  // Sync mode enforces a floor on awake time set by network timing logic
  wire [21:0] eff_wake = (is_sync && wake_period < min_sync_wake_i) ?
                         min_sync_wake_i : wake_period;

  // Write acceptance.
  // A rejected write leaves the old setting untouched and raises no error,
  // since the bus response is always OKAY; software reads back to confirm.
  // Upper data bits must be zero for a timing value to count as in range,
  // otherwise a large value would alias into the accepted window.
  // The option check only refuses the coordinator pair; other bits pass.

  wire mode_ok = (hwdata_i[31:0] == 32'h0) || (hwdata_i == 32'h1) ||
                 (hwdata_i == 32'h4) || (hwdata_i == 32'h5) ||
                 (hwdata_i == 32'h7) || (hwdata_i == 32'h8);
  wire opt_ok = !(hwdata_i[`OPT_PREF_COORD] && hwdata_i[`OPT_NON_COORD]);
  wire wake_ok = (hwdata_i[31:22] == 10'h0) && (hwdata_i[21:0] >= `WAKE_MIN) &&
                 (hwdata_i[21:0] <= `WAKE_MAX);
  wire sleep_ok = (hwdata_i[31:21] == 11'h0) && (hwdata_i[20:0] >= `SLEEP_MIN) &&
                  (hwdata_i[20:0] <= `SLEEP_MAX);
  wire n_ok = (hwdata_i[31:16] == 16'h0) && (hwdata_i[15:0] != 16'h0);
  wire do_wr = wr_pend;

  // Address phase capture.
  // wr_pend marks the data phase of a write; wr_addr keeps its offset.
  // Back-to-back transfers are fine: each address phase overwrites the
  // capture only after the previous data phase has been consumed.
  // The offset is cut to 12 bits; higher address bits are not decoded.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= ahb_go && hwrite_i;
      wr_addr <= haddr_i[11:0];
    end
  end

  // Settings registers.
  // Each field is written only at its own offset and only when valid.
  // Options are masked to the defined bits before they are stored.
  // A mode change takes effect on the sequencer at the next clock:
  // leaving a cyclic mode returns to AWAKE from WAKE, and from SLEEP unless mode 1 sees the pin high; CHECK first ends its window in SLEEP or WAKE.
  // Changing a timing value mid-period affects the running period,
  // because the compare uses the live setting.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode <= `RST_MODE;
      options <= `RST_OPTIONS;
      wake_period <= `RST_WAKE_PERIOD;
      sleep_period <= `RST_SLEEP_PERIOD;
      cycles_per_full_wake <= `RST_CYCLES_PER_FULL_WAKE;
    end else if (do_wr) begin
      if (wr_addr == `OFS_MODE && mode_ok)
        mode <= hwdata_i[3:0];
      if (wr_addr == `OFS_OPTIONS && opt_ok)
        options <= hwdata_i[8:0] & `OPT_DEFINED_MASK;
      if (wr_addr == `OFS_WAKE_PERIOD && wake_ok)
        wake_period <= hwdata_i[21:0];
      if (wr_addr == `OFS_SLEEP_PERIOD && sleep_ok)
        sleep_period <= hwdata_i[20:0];
      if (wr_addr == `OFS_CYCLES_PER_FULL_WAKE && n_ok)
        cycles_per_full_wake <= hwdata_i[15:0];
    end
  end

  // Read data registered at the address phase; zero-wait data phase follows
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0;
    end else if (ahb_go && !hwrite_i) begin
      case (haddr_i[11:0])
        `OFS_MODE: hrdata_o <= {28'h0, mode};
        `OFS_OPTIONS: hrdata_o <= {23'h0, options};
        `OFS_WAKE_PERIOD: hrdata_o <= {10'h0, eff_wake};
        `OFS_SLEEP_PERIOD: hrdata_o <= {11'h0, sleep_period};
        `OFS_MISSED_SYNC_CYCLES: hrdata_o <= {16'h0, missed_sync_cycles};
        `OFS_CYCLES_PER_FULL_WAKE: hrdata_o <= {16'h0, cycles_per_full_wake};
        `OFS_MISSED_SYNC_TALLY: hrdata_o <= {16'h0, missed_sync_tally};
        `OFS_STATUS: hrdata_o <= {28'h0, pin_sync, state};
        default: hrdata_o <= 32'h0;
      endcase
    end
  end

  // The status word reports the synchronised pin and the state code.
  // Reads of the wake period return the effective value, so the sync
  // mode floor is visible to software.
  // Unmapped offsets read zero.

  // Pin passes two flops before any logic looks at it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= sleep_request_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Time base.
  // ms_tick is a one-cycle pulse every 1 ms; ten_tick every tenth of them.
  // Both run freely, so the first tick of a period may come early by up
  // to one tick; this is the price of a single shared divider.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_div <= 16'h0;
      ten_div <= 4'h0;
    end else if (ms_tick) begin
      ms_div <= 16'h0;
      ten_div <= (ten_div == `TEN_MS_PER_MS - 1) ? 4'h0 : ten_div + 4'h1;
    end else begin
      ms_div <= ms_div + 16'h1;
    end
  end

  // With N of one every wake is full; larger N inserts N-1 reduced
  // wakes between full ones.
  // Sync mode ignores N entirely.

  // A full wake is due when the period counter has run N sleeps;
  // sync mode always wakes fully
  wire full_due = is_sync || (period_cnt >= cycles_per_full_wake - 16'h1);

  // Sleep sequencer.
  // asleep_o is the indicator line: low in reset, then high while the device is fully awake.
  // network_wake_o stays low in CHECK, as left by SLEEP, since CHECK never drives it,
  // while asleep_o stays low so the host is not disturbed.
  // In mode 1 the pin level alone decides, with two cycles of latency
  // from the synchroniser.
  // In mode 5 a falling pin edge ends a sleep early and always gives a
  // full wake, whatever the N count says.
  // In modes 4 and 5, data in WAKE restarts the wake window unless the always-wake option
  // is set; data in CHECK promotes the cycle to a full wake.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_AWAKE;
      phase_cnt <= 22'h0;
      period_cnt <= 16'h0;
      asleep_o <= 1'b0;
      network_wake_o <= 1'b1;
    end else begin
      case (state)
        ST_AWAKE: begin
          asleep_o <= 1'b1;
          network_wake_o <= 1'b1;
          phase_cnt <= 22'h0;
          if (mode == `MODE_PIN && pin_sync)
            state <= ST_SLEEP;
          else if (cyclic)
            state <= ST_WAKE;
        end
        ST_SLEEP: begin
          asleep_o <= 1'b0;
          network_wake_o <= 1'b0;
          if (mode == `MODE_PIN) begin
            if (!pin_sync)
              state <= ST_AWAKE;
          end else if (!cyclic) begin
            state <= ST_AWAKE;
          end else if ((mode == `MODE_ASYNC_PIN && pin_fall) ||
                       (ten_tick && phase_cnt + 22'h1 >= {1'b0, sleep_period})) begin
            phase_cnt <= 22'h0;
            if (full_due || (mode == `MODE_ASYNC_PIN && pin_fall)) begin
              period_cnt <= 16'h0;
              asleep_o <= 1'b1;
              state <= ST_WAKE;
            end else begin
              period_cnt <= period_cnt + 16'h1;
              state <= ST_CHECK;
            end
          end else if (ten_tick) begin
            phase_cnt <= phase_cnt + 22'h1;
          end
        end
        ST_WAKE: begin
          asleep_o <= 1'b1;
          network_wake_o <= 1'b1;
          if (!cyclic) begin
            state <= ST_AWAKE;
          end else if (is_async && data_activity_i && !options[`OPT_ALWAYS_WAKE]) begin
            phase_cnt <= 22'h0;
          end else if (ms_tick && phase_cnt + 22'h1 >= eff_wake) begin
            phase_cnt <= 22'h0;
            asleep_o <= 1'b0;
            state <= ST_SLEEP;
          end else if (ms_tick) begin
            phase_cnt <= phase_cnt + 22'h1;
          end
        end
        ST_CHECK: begin
          asleep_o <= 1'b0;
          if (data_activity_i) begin
            phase_cnt <= 22'h0;
            asleep_o <= 1'b1;
            state <= ST_WAKE;
          end else if (ms_tick && phase_cnt + 22'h1 >= `CHECK_MS) begin
            phase_cnt <= 22'h0;
            state <= ST_SLEEP;
          end else if (ms_tick) begin
            phase_cnt <= phase_cnt + 22'h1;
          end
        end
        default: state <= ST_AWAKE;
      endcase
    end
  end

  // Missed sync bookkeeping.
  // The cycle count rises once per sync mode wake start and clears on
  // any received sync message; both counters stop at all ones.

  // Wake-cycle start in sync mode advances the missed-cycle count
  wire wake_start = is_sync && state == ST_SLEEP && ten_tick &&
                    phase_cnt + 22'h1 >= {1'b0, sleep_period};
  wire tally_clr = do_wr && wr_addr == `OFS_MISSED_SYNC_TALLY && hwdata_i == 32'h0;

  // The tally clears only on a write of zero; other written values are
  // ignored, because the tally is not meant to be preset.
  // A miss in the same cycle as the clear is kept, not lost.
  // Writes of zero clear it even outside sync mode.

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      missed_sync_cycles <= 16'h0;
      missed_sync_tally <= 16'h0;
    end else begin
      if (sync_received_i)
        missed_sync_cycles <= 16'h0;
      else if (wake_start && missed_sync_cycles != 16'hffff)
        missed_sync_cycles <= missed_sync_cycles + 16'h1;
      // Event wins over a clear in the same cycle
      if (sync_missed_i && missed_sync_tally != `TALLY_MAX)
        missed_sync_tally <= missed_sync_tally + 16'h1;
      else if (sync_missed_i)
        missed_sync_tally <= missed_sync_tally;
      else if (tally_clr)
        missed_sync_tally <= 16'h0;
    end
  end

endmodule // radio_sleep_wake_controller

// *** verilog/sleep_wake_defs.vh ***
/*
  Constants for the radio sleep and wake controller: register byte offsets,
  field positions, reset values, accepted ranges and time-base counts.
  Assumes a 50 MHz system clock and word-aligned AHB-Lite register access.
*/
`ifndef SLEEP_WAKE_DEFS_VH
`define SLEEP_WAKE_DEFS_VH

// Register byte offsets
`define OFS_MODE 12'h000
`define OFS_OPTIONS 12'h004
`define OFS_WAKE_PERIOD 12'h008
`define OFS_SLEEP_PERIOD 12'h00c
`define OFS_MISSED_SYNC_CYCLES 12'h010
`define OFS_CYCLES_PER_FULL_WAKE 12'h014
`define OFS_MISSED_SYNC_TALLY 12'h018
`define OFS_STATUS 12'h01c

// Sleep mode codes
`define MODE_NEVER 4'h0
`define MODE_PIN 4'h1
`define MODE_ASYNC 4'h4
`define MODE_ASYNC_PIN 4'h5
`define MODE_SUPPORT 4'h7
`define MODE_SYNC 4'h8

// Option bit positions
`define OPT_PREF_COORD 0
`define OPT_NON_COORD 1
`define OPT_STATUS_MSG 2
`define OPT_NO_EARLY_WAKE 3
`define OPT_NODE_EQUAL 4
`define OPT_NO_LONE_REPEAT 5
`define OPT_ALWAYS_WAKE 8
`define OPT_DEFINED_MASK 9'h13f

// Reset values
`define RST_MODE 4'h0
`define RST_OPTIONS 9'h002
`define RST_WAKE_PERIOD 22'h0007d0
`define RST_SLEEP_PERIOD 21'h0000c8
`define RST_CYCLES_PER_FULL_WAKE 16'h0001

// Accepted ranges
`define WAKE_MIN 22'h000045
`define WAKE_MAX 22'h36ee80
`define SLEEP_MIN 21'h000001
`define SLEEP_MAX 21'h15f900
`define TALLY_MAX 16'hffff

// Time base: 1 ms and 10 ms ticks at 50 MHz
`define CLK_HZ 50000000
`define MS_TICK_NS 1000000
`define CLK_NS 20
`define MS_CYCLES (`MS_TICK_NS / `CLK_NS)
`define TEN_MS_PER_MS 10
// Brief data check on reduced wake cycles, in ms
`define CHECK_MS 22'h000001

`endif
